// File: ppf_pkg.sv
/*
 * ppf_pkg: constants for the protected-port forward filter.
 * Assumes a 12-port switch core; one bit per port in every mask.
 */
package ppf_pkg;
  localparam int PPF_PORTS = 12;
  localparam int PPF_PIDW = 4;
  localparam logic [PPF_PORTS-1:0] PPF_ISO_RST = 12'h000;
  localparam logic [PPF_PORTS-1:0] PPF_ALL_PORTS = 12'hFFF;
  typedef logic [PPF_PORTS-1:0] ppf_mask_t;
  typedef logic [PPF_PIDW-1:0] ppf_port_t;
endpackage : ppf_pkg

// File: ppf_filter.sv
/*
 * ppf_filter: narrows the vlan-table egress mask of each frame by the
 * per-port isolation setting.
 * Assumes the forwarding engine presents one frame per valid cycle, and
 * that configuration arrives as a full mask with a one-cycle write strobe.
 * Assumes all inputs are synchronous to ref_clk and that nrst is released
 * clear of a rising edge.
 * The result of each frame is registered and stands until the next frame;
 * a frame taken in the same cycle as a configuration write is judged with
 * the setting that was in force before that write.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - promiscuous ingress: vlan-table mask only
// - isolated ingress: private mask AND vlan mask
// - isolated ingress reaches promiscuous ports only
// - isolated egress only from promiscuous ingress
// - promiscuous egress accepts any ingress
// - one isolation bit per port, all VLANs
// - all ports promiscuous after reset
module ppf_filter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // isolation configuration
  input wire ppf_pkg::ppf_mask_t cfgIsoMask,
  input wire logic cfgIsoWr,
  output ppf_pkg::ppf_mask_t isoMask,
  // frame from forwarding engine
  input wire logic frmValid,
  input wire ppf_pkg::ppf_port_t frmSrcPort,
  input wire ppf_pkg::ppf_mask_t frmVlanMask,
  // filtered result
  output logic outValid,
  output ppf_pkg::ppf_mask_t outMask
);
  import ppf_pkg::*;

  ppf_mask_t isoMask_q;
  ppf_mask_t outMask_q;
  logic outValid_q;
  ppf_mask_t pvlanMask;
  wire ppf_mask_t filtMask;
  logic srcIso;
  logic srcInRange;
  // assertion helpers: what the last taken frame was judged with
  ppf_mask_t chkIso_q;
  ppf_mask_t chkVlan_q;
  logic chkSrcIso_q;
  logic chkRange_q;
  logic seenFrame_q;

  // isolation bit of ingress port; out-of-range ports read promiscuous
  assign srcInRange = (32'(frmSrcPort) < PPF_PORTS);
  assign srcIso = srcInRange ? isoMask_q[frmSrcPort] : 1'b0;
  // private mask keeps promiscuous ports only
  assign pvlanMask = ~isoMask_q;

  // per egress port: an isolated source may reach a port only if that
  // port is promiscuous; a promiscuous source sees the vlan table alone.
  // each bit reads the setting only from the registered mask, so a write can never
  // leave a frame judged against a half-updated mask.
  genvar gp;
  generate
    for (gp = 0; gp < PPF_PORTS; gp = gp + 1) begin : g_egress
      logic egrAllow;
      logic egrPass;
      // the private mask bit gates isolated-source frames only
      assign egrAllow = !srcIso || pvlanMask[gp];
      // the vlan-table bit is always required
      assign egrPass = frmVlanMask[gp] & egrAllow;
      assign filtMask[gp] = egrPass;

      // an isolated egress port never hears an isolated source
      chk_port_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        frmValid && srcIso && isoMask_q[gp] |=> !outMask[gp])
        else $error("isolated port reached from isolated port");

      // a promiscuous egress port follows the vlan table bit
      chk_port_prom: assert property (@(posedge ref_clk) disable iff (!nrst)
        frmValid && !isoMask_q[gp] |=> outMask[gp] == $past(frmVlanMask[gp]))
        else $error("promiscuous port bit altered");

      // no port outside the vlan table is ever added
      chk_port_vlan: assert property (@(posedge ref_clk) disable iff (!nrst)
        frmValid && !frmVlanMask[gp] |=> !outMask[gp])
        else $error("port added outside vlan mask");

      // an isolated egress port does hear a promiscuous source
      chk_port_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
        frmValid && !srcIso && frmVlanMask[gp] |=> outMask[gp])
        else $error("promiscuous source dropped");
    end
  endgenerate

  // isolation register, whole mask replaced in one edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      isoMask_q <= PPF_ISO_RST;
    end else if (cfgIsoWr) begin
      isoMask_q <= cfgIsoMask;
    end
  end

  // registered result, one cycle after frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outValid_q <= 1'b0;
      outMask_q <= '0;
    end else begin
      outValid_q <= frmValid;
      if (frmValid) begin
        outMask_q <= filtMask;
      end
    end
  end

  assign outValid = outValid_q;
  assign outMask = outMask_q;
  assign isoMask = isoMask_q;

  // snapshot of the inputs a frame was judged with, for the checks below
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chkIso_q <= PPF_ISO_RST;
      chkVlan_q <= '0;
      chkSrcIso_q <= 1'b0;
      chkRange_q <= 1'b1;
      seenFrame_q <= 1'b0;
    end else if (frmValid) begin
      chkIso_q <= isoMask_q;
      chkVlan_q <= frmVlanMask;
      chkSrcIso_q <= srcIso;
      chkRange_q <= srcInRange;
      seenFrame_q <= 1'b1;
    end
  end

  // checks
  chk_prom_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid && !srcIso |=> outMask == $past(frmVlanMask))
    else $error("promiscuous ingress mask altered");
  chk_iso_and: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid && srcIso |=> outMask == ($past(frmVlanMask) & ~$past(isoMask_q)))
    else $error("isolated ingress mask wrong");
  chk_no_iso_iso: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid && srcIso |=> (outMask & $past(isoMask_q)) == '0)
    else $error("isolated to isolated forward");
  chk_iso_rx_src: assert property (@(posedge ref_clk) disable iff (!nrst)
    outValid && ((outMask & $past(isoMask_q)) != '0) |-> !$past(srcIso))
    else $error("isolated egress from isolated ingress");
  chk_prom_rx_any: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid |=> ((outMask ^ $past(frmVlanMask)) & ~$past(isoMask_q)) == '0)
    else $error("promiscuous egress dropped");
  chk_subset: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid |=> (outMask & ~$past(frmVlanMask)) == '0)
    else $error("egress outside vlan mask");
  chk_reset_prom: assert property (@(posedge ref_clk)
    $rose(nrst) |-> isoMask_q == PPF_ISO_RST)
    else $error("ports not promiscuous after reset");
  chk_cfg_whole: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfgIsoWr |=> isoMask_q == $past(cfgIsoMask))
    else $error("isolation update not atomic");
  chk_cfg_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfgIsoWr |=> $stable(isoMask_q))
    else $error("isolation setting changed without write");
  chk_valid_lat: assert property (@(posedge ref_clk) disable iff (!nrst)
    frmValid |=> outValid)
    else $error("result valid lost");


  // result stands until the next taken frame
  chk_out_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !frmValid |=> $stable(outMask))
    else $error("result changed without frame");

  // valid is a single-cycle pulse per frame
  chk_valid_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    !frmValid |=> !outValid)
    else $error("result valid without frame");

  // every result matches the setting in force when its frame was taken
  chk_snap_match: assert property (@(posedge ref_clk) disable iff (!nrst)
    outValid |-> outMask == (chkSrcIso_q ? (chkVlan_q & ~chkIso_q) : chkVlan_q))
    else $error("result not from setting at frame time");

  // a frame taken with a write is judged with the old setting
  chk_cfg_next_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfgIsoWr && frmValid |=> chkIso_q == $past(isoMask_q))
    else $error("write applied to its own frame");

  // out-of-range source ports behave as promiscuous
  chk_range_prom: assert property (@(posedge ref_clk) disable iff (!nrst)
    outValid && !chkRange_q |-> outMask == chkVlan_q)
    else $error("out-of-range source filtered");

  // nothing is forwarded before the first frame
  chk_out_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !seenFrame_q |-> !outValid && outMask == '0)
    else $error("result before first frame");

  // outputs sit at reset values as reset is released
  chk_reset_out: assert property (@(posedge ref_clk)
    $rose(nrst) |-> !outValid && outMask == '0)
    else $error("outputs not at reset values");

  // while reset is held every port reads promiscuous
  chk_reset_hold: assert property (@(posedge ref_clk)
    !nrst |-> isoMask_q == PPF_ISO_RST)
    else $error("isolation set during reset");

  // main scenarios
  cov_prom_frame: cover property (@(posedge ref_clk) disable iff (!nrst) frmValid && !srcIso);
  cov_range_frame: cover property (@(posedge ref_clk) disable iff (!nrst) frmValid && !srcInRange);
  cov_iso_frame: cover property (@(posedge ref_clk) disable iff (!nrst) frmValid && srcIso);
  cov_cfg_frame: cover property (@(posedge ref_clk) disable iff (!nrst) cfgIsoWr && frmValid);
endmodule : ppf_filter

// File: ppf_fwd_model.sv
/* ppf_fwd_model: forwarding engine model, one frame per request cycle.
   assumes requests change just after a rising edge. */
`timescale 1ns/1ps
module ppf_fwd_model (
  // clock and request
  input wire logic ref_clk,
  input wire logic req,
  input wire ppf_pkg::ppf_port_t reqSrc,
  input wire ppf_pkg::ppf_mask_t reqVlan,
  // frame to filter
  output logic frmValid = 1'b0,
  output ppf_pkg::ppf_port_t frmSrcPort = 4'h0,
  output ppf_pkg::ppf_mask_t frmVlanMask = 12'h000
);
  import ppf_pkg::*;
  // launch on the falling edge; idle lines toggle so stale values never match
  always @(negedge ref_clk) begin
    frmValid <= req;
    frmSrcPort <= req ? reqSrc : ~frmSrcPort;
    frmVlanMask <= req ? reqVlan : ~frmVlanMask;
  end
endmodule : ppf_fwd_model

// File: ppf_filter_tb.sv
/* ppf_filter_tb: directed tests of the isolation filter.
   assumes the forwarding model launches frames on the falling edge. */
`timescale 1ns/1ps
module ppf_filter_tb;
  import ppf_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, cfgIsoWr = 1'b0, req = 1'b0, frmValid, outValid;
  ppf_mask_t cfgIsoMask = 12'h000, reqVlan = 12'h000, isoMask, frmVlanMask, outMask;
  ppf_port_t reqSrc = 4'h0, frmSrcPort;
  int num_errors = 0, comparisons = 0, cyc = 0;
  // clock and hang limit
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 400) begin num_errors++; complete_run(); end
  ppf_fwd_model u_fwd (.ref_clk(ref_clk), .req(req), .reqSrc(reqSrc), .reqVlan(reqVlan),
    .frmValid(frmValid), .frmSrcPort(frmSrcPort), .frmVlanMask(frmVlanMask));
  ppf_filter u_dut (.ref_clk(ref_clk), .nrst(nrst), .cfgIsoMask(cfgIsoMask), .cfgIsoWr(cfgIsoWr),
    .isoMask(isoMask), .frmValid(frmValid), .frmSrcPort(frmSrcPort), .frmVlanMask(frmVlanMask),
    .outValid(outValid), .outMask(outMask));
  // compare and count
  task automatic check(string name, ppf_mask_t seen, ppf_mask_t exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one frame, judged in the cycle its result stands
  task automatic frame(ppf_port_t src, ppf_mask_t vlan, ppf_mask_t exp);
    @(posedge ref_clk) begin req <= 1'b1; reqSrc <= src; reqVlan <= vlan; end
    @(posedge ref_clk) req <= 1'b0;
    @(negedge ref_clk) check("outValid", {11'h000, outValid}, 12'h001);
    check("outMask", outMask, exp);
    $display("frame test done, source %0d", src);
  endtask : frame
  // whole-mask isolation write
  task automatic cfg(ppf_mask_t m);
    @(negedge ref_clk) begin cfgIsoWr = 1'b1; cfgIsoMask = m; end
    @(negedge ref_clk) cfgIsoWr = 1'b0;
    check("isoMask", isoMask, m);
    $display("config test done");
  endtask : cfg
  // frame taken in the very cycle of a write: old setting applies
  task automatic frame_cfg(ppf_port_t src, ppf_mask_t vlan, ppf_mask_t m, ppf_mask_t exp);
    @(posedge ref_clk) begin req <= 1'b1; reqSrc <= src; reqVlan <= vlan; end
    @(negedge ref_clk) begin cfgIsoWr = 1'b1; cfgIsoMask = m; end
    @(posedge ref_clk) req <= 1'b0;
    @(negedge ref_clk) cfgIsoWr = 1'b0;
    check("outMask", outMask, exp);
    check("isoMask", isoMask, m);
    $display("write-with-frame test done");
  endtask : frame_cfg
  // no frame: valid drops, result stands
  task automatic idle_hold(ppf_mask_t exp);
    @(negedge ref_clk) check("outValid", {11'h000, outValid}, 12'h000);
    check("outMask", outMask, exp);
    $display("hold test done");
  endtask : idle_hold
  // reset in mid-run clears the setting and the result
  task automatic reset_mid();
    @(negedge ref_clk) nrst = 1'b0;
    @(negedge ref_clk) check("isoMask", isoMask, 12'h000);
    check("outMask", outMask, 12'h000);
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    $display("reset test done");
  endtask : reset_mid
  // verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    check("isoMask", isoMask, 12'h000);
    frame(4'h3, 12'hFFF, 12'hFFF);
    cfg(12'h0F0);
    frame(4'h5, 12'hFFF, 12'hF0F);
    frame(4'h1, 12'h0AA, 12'h0AA);
    frame(4'h6, 12'h3C3, 12'h303);
    frame_cfg(4'h5, 12'hFFF, 12'h0C0, 12'hF0F);
    frame(4'h4, 12'hFFF, 12'hFFF);
    frame(4'h7, 12'hFFF, 12'hF3F);
    frame(4'hD, 12'h0FF, 12'h0FF);
    idle_hold(12'h0FF);
    reset_mid();
    frame(4'h7, 12'hFFF, 12'hFFF);
    complete_run();
  end
endmodule : ppf_filter_tb
